// *** io_expander.sv ***
// Serial-bus slave with eight quasi-bidirectional port pins and change interrupt
// Operation
// - Two-wire bus slave, up to Fast-mode rates
// - Eight pins, each input or output, no direction
// - One register, no index or command byte
// - Written output values held in a latch
// - Interrupt low while pins differ from stored inputs
// - Reset: all pins released high as inputs
// - Three straps plus fixed part form address
// - Variants differ only in fixed address part
// - Address byte lsb one reads, zero writes
// - Fixed part 0100 or 0111, bases 20h/38h
// - Reads return sampled pin levels, not latch
`timescale 1ns/1ps
module io_expander #(
    parameter logic [3:0] ADDR_HI = io_expander_pkg::ADDR_HI_BASE
) (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       addr_strap_0_i,
    input  wire logic       addr_strap_1_i,
    input  wire logic       addr_strap_2_i,
    input  wire logic [7:0] port_pin_i,
    output logic      [7:0] port_pin_o,
    output logic      [7:0] port_pin_oe_o,
    output logic            int_n_o,
    output logic            int_n_oe_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    io_expander_pkg::serial_lines_t lines_raw;
    io_expander_pkg::serial_lines_t lines_s;
    logic [7:0]                     pins_s;
    logic [2:0]                     strap_s;

    assign lines_raw.scl = scl_i;
    assign lines_raw.sda = sda_i;

    pin_sync #(
        .WIDTH   (2),
        .RST_VAL (io_expander_pkg::LINES_RST)
    ) u_sync_lines (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    (lines_raw),
        .sync_o     (lines_s)
    );

    pin_sync #(
        .WIDTH   (io_expander_pkg::PORT_W),
        .RST_VAL (io_expander_pkg::IN_STORE_RST)
    ) u_sync_pins (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    (port_pin_i),
        .sync_o     (pins_s)
    );

    pin_sync #(
        .WIDTH   (io_expander_pkg::STRAP_W),
        .RST_VAL (io_expander_pkg::STRAP_RST)
    ) u_sync_strap (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    ({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i}),
        .sync_o     (strap_s)
    );

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    io_expander_pkg::serial_lines_t lines_prev_q;
    logic                           scl_rise;
    logic                           scl_fall;
    logic                           start_cond;
    logic                           stop_cond;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lines_prev_q <= io_expander_pkg::LINES_RST;
        end else begin
            lines_prev_q <= lines_s;
        end
    end

    // Edges sampled well above Fast-mode rate on the core clock
    assign scl_rise   = lines_s.scl & ~lines_prev_q.scl;
    assign scl_fall   = ~lines_s.scl & lines_prev_q.scl;
    assign start_cond = lines_s.scl & lines_prev_q.scl & lines_prev_q.sda & ~lines_s.sda;
    assign stop_cond  = lines_s.scl & lines_prev_q.scl & ~lines_prev_q.sda & lines_s.sda;

    // ------------------------------------------------------------
    // Address match and decode
    // ------------------------------------------------------------
    io_expander_pkg::bus_state_t state_q;
    io_expander_pkg::bus_state_t state_d;
    logic [7:0]                  shift_q;
    logic [7:0]                  shift_d;
    logic [3:0]                  cnt_q;
    logic [3:0]                  cnt_d;
    logic                        rd_q;
    logic                        rd_d;
    logic                        nack_q;
    logic                        nack_d;
    logic                        sda_oe_d;
    logic [7:0]                  drive_low_d;
    logic [7:0]                  in_store_d;
    logic [7:0]                  in_store_q;
    logic [6:0]                  own_addr;
    logic                        addr_match;
    logic                        byte_done;
    logic                        int_hit;

    assign own_addr   = {ADDR_HI, strap_s};
    assign addr_match = (shift_q[7:1] == own_addr);
    assign byte_done  = (cnt_q == io_expander_pkg::BYTE_BITS);
    assign int_hit    = (pins_s != in_store_d);

    // ------------------------------------------------------------
    // Transfer state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        shift_d     = shift_q;
        cnt_d       = cnt_q;
        rd_d        = rd_q;
        nack_d      = nack_q;
        sda_oe_d    = sda_oe_o;
        drive_low_d = port_pin_oe_o;
        in_store_d  = in_store_q;
        if (start_cond) begin
            state_d  = io_expander_pkg::ST_ADDR;
            cnt_d    = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_cond) begin
            state_d  = io_expander_pkg::ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                io_expander_pkg::ST_ADDR, io_expander_pkg::ST_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        shift_d = {shift_q[6:0], lines_s.sda};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        cnt_d = 4'h0;
                        if (state_q == io_expander_pkg::ST_WDATA) begin
                            // No index byte: every data byte goes to the latch
                            drive_low_d = ~shift_q;
                            sda_oe_d    = 1'b1;
                            state_d     = io_expander_pkg::ST_WACK;
                        end else if (addr_match) begin
                            rd_d     = shift_q[0];
                            sda_oe_d = 1'b1;
                            state_d  = io_expander_pkg::ST_ADDR_ACK;
                        end else begin
                            state_d = io_expander_pkg::ST_IDLE;
                        end
                    end
                end
                io_expander_pkg::ST_ADDR_ACK, io_expander_pkg::ST_RACK: begin
                    if (scl_rise && state_q == io_expander_pkg::ST_RACK) begin
                        nack_d = lines_s.sda;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (!rd_q) begin
                            sda_oe_d = 1'b0;
                            state_d  = io_expander_pkg::ST_WDATA;
                        end else if (state_q == io_expander_pkg::ST_RACK && nack_q) begin
                            sda_oe_d = 1'b0;
                            state_d  = io_expander_pkg::ST_IDLE;
                        end else begin
                            // Pin levels, not the latch, are returned and stored
                            shift_d    = pins_s;
                            in_store_d = pins_s;
                            sda_oe_d   = ~pins_s[7];
                            state_d    = io_expander_pkg::ST_RDATA;
                        end
                    end
                end
                io_expander_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        state_d  = io_expander_pkg::ST_WDATA;
                    end
                end
                io_expander_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h7) begin
                            sda_oe_d = 1'b0;
                            nack_d   = 1'b0;
                            state_d  = io_expander_pkg::ST_RACK;
                        end else begin
                            shift_d  = {shift_q[6:0], 1'b0};
                            sda_oe_d = ~shift_q[6];
                            cnt_d    = cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= io_expander_pkg::ST_IDLE;
            shift_q <= io_expander_pkg::SHIFT_RST;
            cnt_q   <= 4'h0;
            rd_q    <= 1'b0;
            nack_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            rd_q    <= rd_d;
            nack_q  <= nack_d;
        end
    end

    // Open-drain pins: only ever pulled low when enabled
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_o         <= 1'b0;
            sda_oe_o      <= 1'b0;
            port_pin_o    <= 8'h00;
            port_pin_oe_o <= io_expander_pkg::DRIVE_LOW_RST;
            in_store_q    <= io_expander_pkg::IN_STORE_RST;
            int_n_o       <= 1'b0;
            int_n_oe_o    <= 1'b0;
        end else begin
            sda_oe_o      <= sda_oe_d;
            port_pin_oe_o <= drive_low_d;
            in_store_q    <= in_store_d;
            int_n_oe_o    <= int_hit;
        end
    end

endmodule

// *** io_expander_pkg.sv ***
// Shared constants and types for the serial I/O expander
package io_expander_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int unsigned PORT_W    = 8;
    localparam int unsigned STRAP_W   = 3;
    localparam logic [3:0]  BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // Fixed upper address part, one per variant
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_HI_BASE = 4'h4;
    localparam logic [3:0] ADDR_HI_ALT  = 4'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IN_STORE_RST  = 8'hff;
    localparam logic [7:0] DRIVE_LOW_RST = 8'h00;
    localparam logic [7:0] SHIFT_RST     = 8'h00;
    localparam logic [1:0] LINES_RST     = 2'h3;
    localparam logic [2:0] STRAP_RST     = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } serial_lines_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } bus_state_t;

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// *** io_expander_monitor.sv ***
// Port checker for the I/O expander
`timescale 1ns/1ps
module io_expander_monitor (
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       addr_strap_0_i,
    input wire logic       addr_strap_1_i,
    input wire logic       addr_strap_2_i,
    input wire logic [7:0] port_pin_i,
    input wire logic [7:0] port_pin_o,
    input wire logic [7:0] port_pin_oe_o,
    input wire logic       int_n_o,
    input wire logic       int_n_oe_o
);
    logic [3:0] scl_age_q;
    logic [3:0] pin_age_q;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // ----
    // Cycles since bus clock fall and pin change
    // ----
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_age_q <= 4'hf;
            pin_age_q <= 4'hf;
        end else begin
            scl_age_q <= $fell(scl_i) ? 4'h0 : scl_age_q + {3'h0, scl_age_q != 4'hf};
            pin_age_q <= $changed(port_pin_i) ? 4'h0 : pin_age_q + {3'h0, pin_age_q != 4'hf};
        end
    end
    sequence quiet_s;
        port_pin_oe_o == 8'h00 && !int_n_oe_o && !sda_oe_o;
    endsequence
    sequence scl_high_s;
        scl_i [*4];
    endsequence
    // ----
    // Assertions
    // ----
    AST_RST_QUIET: assert property ($rose(resetn_i) |-> quiet_s [*3])
        else $error("outputs busy after reset");
    AST_SDA_OPEN: assert property (sda_o == 1'b0)
        else $error("data driven high");
    AST_SDA_ON_FALL: assert property ($rose(sda_oe_o) |-> scl_age_q <= 4'h4)
        else $error("data pulled away from clock fall");
    AST_SDA_STEADY: assert property (scl_high_s |-> $stable(sda_oe_o))
        else $error("data moved while clock high");
    AST_PIN_OPEN: assert property (port_pin_o == 8'h00)
        else $error("pin driven high");
    AST_LATCH_HOLD: assert property ($changed(port_pin_oe_o) |-> scl_age_q <= 4'h4)
        else $error("latch moved without a write");
    AST_INT_OPEN: assert property (int_n_o == 1'b0)
        else $error("interrupt driven high");
    AST_INT_CAUSE: assert property ($rose(int_n_oe_o) |-> pin_age_q <= 4'h5)
        else $error("interrupt without pin change");
    AST_INT_CLEAR: assert property ($fell(int_n_oe_o) |-> pin_age_q <= 4'h5 || scl_age_q <= 4'h5)
        else $error("interrupt released without cause");
endmodule

bind io_expander io_expander_monitor i_monitor (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_0_i(addr_strap_0_i),
    .addr_strap_1_i(addr_strap_1_i), .addr_strap_2_i(addr_strap_2_i),
    .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));

// *** bus_master_model.sv ***
// Serial bus master model with open-drain data
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic half_wait();
        repeat (6) @(posedge core_clk_i);
        #1;
    endtask
    task automatic bit_cycle(input logic send, output logic seen);
        sda_pull_o = ~send;
        half_wait();
        scl_o = 1'b1;
        half_wait();
        seen = sda_i;
        scl_o = 1'b0;
        half_wait();
    endtask
    task automatic start_cond();
        sda_pull_o = 1'b0;
        half_wait();
        scl_o = 1'b1;
        half_wait();
        sda_pull_o = 1'b1;
        half_wait();
        scl_o = 1'b0;
        half_wait();
    endtask
    task automatic stop_cond();
        sda_pull_o = 1'b1;
        half_wait();
        scl_o = 1'b1;
        half_wait();
        sda_pull_o = 1'b0;
        half_wait();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    task automatic write_port(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic k;
        start_cond();
        send_byte({a, 1'b0}, ack);
        if (ack) begin
            send_byte(d, k);
            ack = k;
        end
        stop_cond();
    endtask
    task automatic read_port(input logic [6:0] a, output logic [7:0] d, output logic ack);
        logic s;
        d = 8'h00;
        start_cond();
        send_byte({a, 1'b1}, ack);
        if (ack) begin
            for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
            bit_cycle(1'b1, s);
        end
        stop_cond();
    endtask
endmodule

// *** test_i2c_quasi_bidir_io_expander.sv ***
// Testbench for the I/O expander
`timescale 1ns/1ps
module test_i2c_quasi_bidir_io_expander;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [7:0] ext_low = 8'h00;
    logic       scl, sda_pull, sda_oe, alt_sda_oe, int_oe, ack;
    logic [7:0] pin_oe, alt_oe, rd;
    logic [6:0] base_addr;
    int         fails = 0;
    int         cmp_count = 0;
    wire        sda = ~(sda_pull | sda_oe | alt_sda_oe);
    wire  [7:0] pin = ~(pin_oe | ext_low);
    assign base_addr = {io_expander_pkg::ADDR_HI_BASE, strap};
    always #12.5 clk = ~clk;
    bus_master_model i_master (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
    io_expander #(.ADDR_HI(io_expander_pkg::ADDR_HI_BASE)) i_dut (
        .core_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .addr_strap_0_i(strap[0]), .addr_strap_1_i(strap[1]),
        .addr_strap_2_i(strap[2]), .port_pin_i(pin), .port_pin_o(), .port_pin_oe_o(pin_oe),
        .int_n_o(), .int_n_oe_o(int_oe));
    io_expander #(.ADDR_HI(io_expander_pkg::ADDR_HI_ALT)) i_dut_alt (
        .core_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(alt_sda_oe), .addr_strap_0_i(strap[0]), .addr_strap_1_i(strap[1]),
        .addr_strap_2_i(strap[2]), .port_pin_i(~alt_oe), .port_pin_o(),
        .port_pin_oe_o(alt_oe), .int_n_o(), .int_n_oe_o());
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic test_reset();
        check(pin_oe, 8'h00);
        check({7'h0, int_oe}, 8'h00);
        i_master.read_port(7'h20, rd, ack);
        check({7'h0, ack}, 8'h01);
        check(rd, 8'hff);
        $display("test_reset done");
    endtask
    task automatic test_write_read();
        i_master.write_port(base_addr, 8'h5a, ack);
        check({7'h0, ack}, 8'h01);
        settle();
        check(pin_oe, 8'ha5);
        check({7'h0, int_oe}, 8'h01);
        i_master.read_port(base_addr, rd, ack);
        check(rd, 8'h5a);
        check({7'h0, int_oe}, 8'h00);
        check(pin_oe, 8'ha5);
        check(alt_oe, 8'h00);
        $display("test_write_read done");
    endtask
    task automatic test_mid_reset();
        i_master.write_port(base_addr, 8'h0f, ack);
        check({7'h0, ack}, 8'h01);
        settle();
        check(pin_oe, 8'hf0);
        resetn = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(pin_oe, 8'h00);
        check({7'h0, int_oe}, 8'h00);
        resetn = 1'b1;
        settle();
        i_master.read_port(base_addr, rd, ack);
        check(rd, 8'hff);
        $display("test_mid_reset done");
    endtask
    task automatic test_ext();
        i_master.write_port(base_addr, 8'hff, ack);
        i_master.read_port(base_addr, rd, ack);
        ext_low = 8'h08;
        settle();
        check({7'h0, int_oe}, 8'h01);
        i_master.read_port(base_addr, rd, ack);
        check(rd, 8'hf7);
        check({7'h0, int_oe}, 8'h00);
        ext_low = 8'h00;
        settle();
        check({7'h0, int_oe}, 8'h01);
        ext_low = 8'h08;
        settle();
        check({7'h0, int_oe}, 8'h00);
        $display("test_ext done");
    endtask
    task automatic test_addr();
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            settle();
            i_master.write_port(base_addr, 8'(s), ack);
            check({7'h0, ack}, 8'h01);
            i_master.write_port(base_addr ^ 7'h01, 8'hff, ack);
            check({7'h0, ack}, 8'h00);
            i_master.write_port({4'h7, strap}, 8'(s) ^ 8'hc3, ack);
            check({7'h0, ack}, 8'h01);
            settle();
            check(pin_oe, ~8'(s));
            check(alt_oe, ~(8'(s) ^ 8'hc3));
        end
        $display("test_addr done");
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        settle();
        test_reset();
        test_write_read();
        test_mid_reset();
        test_ext();
        test_addr();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        $display("Run cut short");
        test_done();
    end
endmodule
